// [logic/wdt_pkg.sv]
// Constants for the watchdog timer unit
//
// Behaviour
// - Timer runs in normal timing mode or in watchdog supervision mode.
// - Counter reloads from the reload register on any service write, on watchdog expiry and on overflow in periodic mode.
// - Normal mode: 16-bit timer on the 32.768 kHz tick, divided 1, 16 or 256.
// - Setting control bit 5 enters watchdog mode.
// - Watchdog mode counts down from the reload value to zero.
// - Divide-by-256 with full-scale reload gives a 512 second timeout.
// - At zero the watchdog resets the processor or interrupts, chosen by control bit 1.
// - Once in watchdog mode, reload and control writes are ignored until power-on reset.
// - Only power-on reset stops the watchdog or clears its configuration.
// - Counter freezes while the debug port holds the core.
// - Counter runs in peripheral power-down unless control bit 0 is set.
// - Reload and count are 16-bit unsigned; the count register is read-only.
// - Service write clears the interrupt in normal mode, restarts timeout in watchdog.
// - Prescale bits 3-2: 00 /1, 01 /16, 10 /256, 11 reserved.
// - Control bit 8 selects up-counting, bit 7 enables the timer.
// - Control bit 6 selects periodic mode, clear means free-running.
// - Control bit 1 set gives interrupt on expiry, clear gives processor reset.
package wdt_pkg;
  ////////////////////////////////////////////////////////////////////////////////
  // Register byte addresses
  localparam logic [31:0] LOAD_ADDR = 32'hFFFF_0360;
  localparam logic [31:0] VALUE_ADDR = 32'hFFFF_0364;
  localparam logic [31:0] CTRL_ADDR = 32'hFFFF_0368;
  localparam logic [31:0] SVC_ADDR = 32'hFFFF_036C;
  ////////////////////////////////////////////////////////////////////////////////
  // Reset values and implemented control bits
  localparam logic [15:0] LOAD_RST = 16'h0040;
  localparam logic [15:0] VALUE_RST = 16'h0040;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] CTRL_MASK = 16'h01EF;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  ////////////////////////////////////////////////////////////////////////////////
  // Control field positions
  localparam int CTRL_UP = 8;
  localparam int CTRL_EN = 7;
  localparam int CTRL_PERIODIC = 6;
  localparam int CTRL_WDOG = 5;
  localparam int CTRL_PRE_HI = 3;
  localparam int CTRL_PRE_LO = 2;
  localparam int CTRL_IRQ_SEL = 1;
  localparam int CTRL_PD_HALT = 0;
  ////////////////////////////////////////////////////////////////////////////////
  // Prescale codes and terminal counts
  localparam logic [1:0] PRE_DIV1 = 2'h0;
  localparam logic [1:0] PRE_DIV16 = 2'h1;
  localparam logic [1:0] PRE_DIV256 = 2'h2;
  localparam logic [7:0] PRE_LIM1 = 8'h00;
  localparam logic [7:0] PRE_LIM16 = 8'h0F;
  localparam logic [7:0] PRE_LIM256 = 8'hFF;
  ////////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int LP_OSC_HZ = 32768;
  localparam int MCLK_HZ = 100000000;
  localparam int MAX_TIMEOUT_S = 512;
  localparam int MIN_TIMEOUT_MS = 30;
  localparam int SVC_WIDTH = 8;
endpackage : wdt_pkg

// [logic/wdt_watchdog_timer_unit.sv]
// Watchdog / general timer with register port and low-power tick input
//
// The plain strobed port was decided locally.
module wdt_watchdog_timer_unit (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [31:0] addr,
  input wire logic [31:0] wrData,
  input wire logic wrEn,
  input wire logic rdEn,
  output logic [31:0] rdData,
  input wire logic lpOscClk,
  input wire logic debugHalt,
  input wire logic periphPowerDown,
  output logic wdResetReq,
  output logic timerIrq,
  output logic wdModeActive
);

  typedef struct packed {
    logic [2:0] lpSync;
    logic lpLevel;
    logic [7:0] pre;
    logic [15:0] load;
    logic [15:0] count;
    logic [15:0] ctrl;
    logic irq;
    logic rstReq;
    logic [31:0] rdData;
  } wdt_state_t;

  wdt_state_t s_q;
  wdt_state_t s_d;
  logic lpRise;
  logic tick;
  logic running;
  logic frozen;
  logic svcWr;
  logic wdMode;
  logic expire;
  logic wrap;

  ////////////////////////////////////////////////////////////////////////////////
  // Prescale terminal count
  function automatic logic [7:0] preLimit(input logic [1:0] code);
    unique case (code)
      wdt_pkg::PRE_DIV16: preLimit = wdt_pkg::PRE_LIM16;
      wdt_pkg::PRE_DIV256: preLimit = wdt_pkg::PRE_LIM256;
      default: preLimit = wdt_pkg::PRE_LIM1;
    endcase
  endfunction : preLimit

  ////////////////////////////////////////////////////////////////////////////////
  // Register address match, full 32-bit compare
  function automatic logic regHit(input logic [31:0] a, input logic [31:0] target);
    regHit = (a == target);
  endfunction : regHit

  ////////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    s_d = s_q;
    lpRise = 1'b0;
    expire = 1'b0;
    wrap = 1'b0;
    // Tick synchroniser, edge taken once second and third stages agree
    s_d.lpSync = {s_q.lpSync[1:0], lpOscClk};
    if (s_q.lpSync[2] == s_q.lpSync[1] && s_q.lpSync[1] != s_q.lpLevel) begin
      s_d.lpLevel = s_q.lpSync[1];
      lpRise = s_q.lpSync[1];
    end
    wdMode = s_q.ctrl[wdt_pkg::CTRL_WDOG];
    running = s_q.ctrl[wdt_pkg::CTRL_EN] | wdMode;
    frozen = debugHalt | (s_q.ctrl[wdt_pkg::CTRL_PD_HALT] & periphPowerDown);
    tick = running && !frozen && lpRise
        && (s_q.pre == preLimit(s_q.ctrl[wdt_pkg::CTRL_PRE_HI:wdt_pkg::CTRL_PRE_LO]));
    svcWr = wrEn && regHit(addr, wdt_pkg::SVC_ADDR);
    // Prescaler advances on each rising oscillator edge while running and not frozen
    if (running && !frozen && lpRise) begin
      s_d.pre = tick ? 8'h00 : 8'(s_q.pre + 8'h01);
    end
    // Counter
    if (svcWr) begin
      s_d.count = s_q.load;
      s_d.pre = 8'h00;
    end else if (tick) begin
      if (wdMode) begin
        if (s_q.count <= 16'h0001) begin
          expire = 1'b1;
          s_d.count = s_q.load;
        end else begin
          s_d.count = 16'(s_q.count - 16'h0001);
        end
      end else if (s_q.ctrl[wdt_pkg::CTRL_UP]) begin
        if (s_q.count == wdt_pkg::COUNT_MAX) begin
          wrap = 1'b1;
          s_d.count = s_q.ctrl[wdt_pkg::CTRL_PERIODIC] ? s_q.load : 16'h0000;
        end else begin
          s_d.count = 16'(s_q.count + 16'h0001);
        end
      end else begin
        if (s_q.count == 16'h0000) begin
          wrap = 1'b1;
          s_d.count = s_q.ctrl[wdt_pkg::CTRL_PERIODIC] ? s_q.load : wdt_pkg::COUNT_MAX;
        end else begin
          s_d.count = 16'(s_q.count - 16'h0001);
        end
      end
    end
    // Interrupt flag, a service clear wins since a service write suppresses the tick event of that cycle
    if (svcWr) begin
      s_d.irq = 1'b0;
    end
    if (wrap || (expire && s_q.ctrl[wdt_pkg::CTRL_IRQ_SEL])) begin
      s_d.irq = 1'b1;
    end
    s_d.rstReq = expire && !s_q.ctrl[wdt_pkg::CTRL_IRQ_SEL];
    // Register writes, locked once watchdog mode is on
    if (wrEn && !wdMode && regHit(addr, wdt_pkg::LOAD_ADDR)) begin
      s_d.load = wrData[15:0];
    end
    if (wrEn && !wdMode && regHit(addr, wdt_pkg::CTRL_ADDR)) begin
      s_d.ctrl = wrData[15:0] & wdt_pkg::CTRL_MASK;
    end
    // Read data stands only in the cycle after the read strobe
    s_d.rdData = 32'h0000_0000;
    if (rdEn) begin
      unique case (addr)
        wdt_pkg::LOAD_ADDR: s_d.rdData = {16'h0000, s_q.load};
        wdt_pkg::VALUE_ADDR: s_d.rdData = {16'h0000, s_q.count};
        wdt_pkg::CTRL_ADDR: s_d.rdData = {16'h0000, s_q.ctrl};
        default: s_d.rdData = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register, cleared only by power-on reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_q <= '{
        lpSync: 3'h0,
        lpLevel: 1'b0,
        pre: 8'h00,
        load: wdt_pkg::LOAD_RST,
        count: wdt_pkg::VALUE_RST,
        ctrl: wdt_pkg::CTRL_RST,
        irq: 1'b0,
        rstReq: 1'b0,
        rdData: 32'h0000_0000
      };
    end else begin
      s_q <= s_d;
    end
  end

  assign rdData = s_q.rdData;
  assign wdResetReq = s_q.rstReq;
  assign timerIrq = s_q.irq;
  assign wdModeActive = s_q.ctrl[wdt_pkg::CTRL_WDOG];

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  sequence svcWrite;
    wrEn && addr == wdt_pkg::SVC_ADDR;
  endsequence

  sequence lockedWrite(logic [31:0] a);
    wrEn && wdMode && addr == a;
  endsequence

  sequence wdExpiry;
    tick && wdMode && !svcWr && s_q.count <= 16'h0001;
  endsequence

  sequence normalUp;
    tick && !wdMode && !svcWr && s_q.ctrl[wdt_pkg::CTRL_UP];
  endsequence

  sequence normalDown;
    tick && !wdMode && !svcWr && !s_q.ctrl[wdt_pkg::CTRL_UP];
  endsequence

  sequence openWrite(logic [31:0] a);
    wrEn && !wdMode && addr == a;
  endsequence

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog checks
  serviceReload_a: assert property (svcWrite |=> s_q.count == $past(s_q.load))
    else $error("Service write did not reload the counter");

  loadLocked_a: assert property (lockedWrite(wdt_pkg::LOAD_ADDR) |=> $stable(s_q.load))
    else $error("Reload register changed while locked");

  ctrlLocked_a: assert property (lockedWrite(wdt_pkg::CTRL_ADDR) |=> $stable(s_q.ctrl))
    else $error("Control register changed while locked");

  debugFreeze_a: assert property (debugHalt && !svcWr |=> $stable(s_q.count))
    else $error("Counter moved during debug halt");

  pdFreeze_a: assert property (
      s_q.ctrl[wdt_pkg::CTRL_PD_HALT] && periphPowerDown && !svcWr |=> $stable(s_q.count))
    else $error("Counter moved during halted power-down");

  resetPulse_a: assert property (
      wdExpiry ##0 !s_q.ctrl[wdt_pkg::CTRL_IRQ_SEL] |=> wdResetReq ##1 !wdResetReq)
    else $error("Expiry reset request is not a single pulse");

  expiryIrq_a: assert property (
      wdExpiry ##0 s_q.ctrl[wdt_pkg::CTRL_IRQ_SEL] |=> timerIrq && !wdResetReq)
    else $error("Expiry with interrupt option did not raise the interrupt");

  wdDown_a: assert property (
      tick && wdMode && !svcWr && s_q.count > 16'h0001
      |=> s_q.count == 16'($past(s_q.count) - 16'h0001))
    else $error("Watchdog count did not step down");

  readLatency_a: assert property (
      rdEn && addr == wdt_pkg::VALUE_ADDR |=> rdData == {16'h0000, $past(s_q.count)})
    else $error("Count read returned wrong data");

  irqHold_a: assert property (timerIrq && !svcWr |=> timerIrq)
    else $error("Interrupt flag dropped without service write");

  wdReload_a: assert property (
      wdExpiry |=> s_q.count == $past(s_q.load))
    else $error("Watchdog did not reload at expiry");

  noReqNormal_a: assert property (
      !wdMode |=> !wdResetReq)
    else $error("Reset request outside watchdog mode");

  modeSticky_a: assert property (
      wdModeActive |=> wdModeActive)
    else $error("Watchdog mode left without power-on reset");

  irqNoReset_a: assert property (
      s_q.ctrl[wdt_pkg::CTRL_IRQ_SEL] |=> !wdResetReq)
    else $error("Reset request with interrupt option selected");

  pulseOnly_a: assert property (
      wdResetReq |=> !wdResetReq)
    else $error("Reset request longer than one cycle");

  wdIgnoresUp_a: assert property (
      tick && wdMode && !svcWr && s_q.ctrl[wdt_pkg::CTRL_UP] && s_q.count > 16'h0001
      |=> s_q.count < $past(s_q.count))
    else $error("Watchdog counted up");

  ////////////////////////////////////////////////////////////////////////////////
  // Register port checks
  valueRo_a: assert property (
      wrEn && addr == wdt_pkg::VALUE_ADDR && !tick |=> $stable(s_q.count))
    else $error("Write to the count register moved the counter");

  loadWrite_a: assert property (
      openWrite(wdt_pkg::LOAD_ADDR) |=> s_q.load == $past(wrData[15:0]))
    else $error("Reload register write lost");

  ctrlWrite_a: assert property (
      openWrite(wdt_pkg::CTRL_ADDR) |=> s_q.ctrl == ($past(wrData[15:0]) & wdt_pkg::CTRL_MASK))
    else $error("Control register write lost");

  ctrlMask_a: assert property (
      (s_q.ctrl & ~wdt_pkg::CTRL_MASK) == 16'h0000)
    else $error("Unimplemented control bit set");

  loadNoReload_a: assert property (
      wrEn && addr == wdt_pkg::LOAD_ADDR && !tick |=> $stable(s_q.count))
    else $error("Reload register write moved the counter");

  readIdle_a: assert property (
      !rdEn |=> rdData == 32'h0000_0000)
    else $error("Read data without read strobe");

  readLoad_a: assert property (
      rdEn && addr == wdt_pkg::LOAD_ADDR |=> rdData == {16'h0000, $past(s_q.load)})
    else $error("Reload read returned wrong data");

  readCtrl_a: assert property (
      rdEn && addr == wdt_pkg::CTRL_ADDR |=> rdData == {16'h0000, $past(s_q.ctrl)})
    else $error("Control read returned wrong data");

  readSvc_a: assert property (
      rdEn && addr == wdt_pkg::SVC_ADDR |=> rdData == 32'h0000_0000)
    else $error("Service register read not zero");

  svcClear_a: assert property (
      svcWr && !wrap && !expire |=> !timerIrq)
    else $error("Service write did not clear the interrupt");

  setWins_a: assert property (
      wrap || (expire && s_q.ctrl[wdt_pkg::CTRL_IRQ_SEL]) |=> timerIrq)
    else $error("Interrupt event lost");

  ////////////////////////////////////////////////////////////////////////////////
  // Counter and prescaler checks
  upStep_a: assert property (
      normalUp ##0 s_q.count != wdt_pkg::COUNT_MAX
      |=> s_q.count == 16'($past(s_q.count) + 16'h0001))
    else $error("Up count did not step");

  downStep_a: assert property (
      normalDown ##0 s_q.count != 16'h0000
      |=> s_q.count == 16'($past(s_q.count) - 16'h0001))
    else $error("Down count did not step");

  upWrap_a: assert property (
      normalUp ##0 s_q.count == wdt_pkg::COUNT_MAX |=> timerIrq
      && s_q.count == ($past(s_q.ctrl[wdt_pkg::CTRL_PERIODIC]) ? $past(s_q.load) : 16'h0000))
    else $error("Up overflow handled wrongly");

  downWrap_a: assert property (
      normalDown ##0 s_q.count == 16'h0000 |=> timerIrq && s_q.count
      == ($past(s_q.ctrl[wdt_pkg::CTRL_PERIODIC]) ? $past(s_q.load) : wdt_pkg::COUNT_MAX))
    else $error("Down underflow handled wrongly");

  idleHold_a: assert property (
      !tick && !svcWr |=> $stable(s_q.count))
    else $error("Counter moved without tick");

  stoppedHold_a: assert property (
      !running && !svcWr |=> $stable(s_q.count))
    else $error("Disabled timer moved");

  svcPrescale_a: assert property (
      svcWrite |=> s_q.pre == 8'h00)
    else $error("Service write did not restart the divider");

  debugPrescale_a: assert property (
      debugHalt && !svcWr |=> $stable(s_q.pre))
    else $error("Divider moved during debug halt");

  pdRun_a: assert property (
      lpRise && running && !debugHalt && !s_q.ctrl[wdt_pkg::CTRL_PD_HALT] && !svcWr && !tick
      |=> s_q.pre == 8'($past(s_q.pre) + 8'h01))
    else $error("Divider did not advance");

  tickClears_a: assert property (
      tick && !svcWr |=> s_q.pre == 8'h00)
    else $error("Divider not restarted after tick");

  tickOnce_a: assert property (
      tick |=> !tick)
    else $error("Tick longer than one cycle");

  edgeAgree_a: assert property (
      lpRise |-> s_q.lpSync[2] && s_q.lpSync[1])
    else $error("Oscillator edge taken before stages agree");

endmodule : wdt_watchdog_timer_unit

// [test/test_watchdog_timer_unit.sv]
// Self-checking bench for the watchdog timer unit
`define CHK(n, e, g) begin checksDone++; if ((g) !== (e)) begin fails++; \
  $display("mismatch %s expected %h seen %h", n, e, g); end end
module test_watchdog_timer_unit;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, rst = 1'b1, wrEn = 1'b0, rdEn = 1'b0, lpOscClk = 1'b0;
  logic debugHalt = 1'b0, periphPowerDown = 1'b0, expIrq;
  logic [31:0] addr = 32'h0000_0000, wrData = 32'h0000_0000, rd, rdData;
  logic wdResetReq, timerIrq, wdModeActive;
  logic [15:0] lfsr = 16'h83C6, v, ld, ctl, r;
  logic [15:0] modes [5] = '{16'h0080, 16'h00C0, 16'h0180, 16'h01C0, 16'h00CC};
  int fails = 0, checksDone = 0, cycles = 0, pulses = 0;
  wdt_watchdog_timer_unit wdt_watchdog_timer_unit_inst (.mclk(mclk), .rst(rst), .addr(addr),
    .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .lpOscClk(lpOscClk),
    .debugHalt(debugHalt), .periphPowerDown(periphPowerDown), .wdResetReq(wdResetReq),
    .timerIrq(timerIrq), .wdModeActive(wdModeActive));
  ////////////////////////////////////////////////////////////////////////////////
  initial forever #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (wdResetReq === 1'b1) pulses++;
    if (cycles == 20000) begin
      fails++;
      stop_test();
    end
  end
  function logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction : rnd
  function logic [15:0] expNext(input logic [15:0] c, input logic [15:0] l, input logic [15:0] m);
    if (m[8]) return (c == 16'hFFFF) ? (m[6] ? l : 16'h0000) : c + 16'h0001;
    return (c == 16'h0000) ? (m[6] ? l : 16'hFFFF) : c - 16'h0001;
  endfunction : expNext
  ////////////////////////////////////////////////////////////////////////////////
  task busWrite(input logic [31:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    wrData <= {16'h0000, d};
    wrEn <= 1'b1;
    @(posedge mclk);
    wrEn <= 1'b0;
  endtask : busWrite
  task chkVal(input string n, input logic [31:0] a, input logic [15:0] e);
    @(posedge mclk);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge mclk);
    rdEn <= 1'b0;
    #1 rd = rdData;
    `CHK(n, {16'h0000, e}, rd)
  endtask : chkVal
  task tick();
    @(posedge mclk);
    lpOscClk <= 1'b1;
    repeat (6) @(posedge mclk);
    lpOscClk <= 1'b0;
    repeat (6) @(posedge mclk);
  endtask : tick
  task doReset();
    @(posedge mclk);
    rst <= 1'b1;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
  endtask : doReset
  task stop_test();
    $display("counts: %0d checks, %0d mismatches", checksDone, fails);
    if (fails == 0 && checksDone > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    doReset();
    chkVal("load", wdt_pkg::LOAD_ADDR, wdt_pkg::LOAD_RST);
    chkVal("value", wdt_pkg::VALUE_ADDR, wdt_pkg::VALUE_RST);
    chkVal("ctrl", wdt_pkg::CTRL_ADDR, wdt_pkg::CTRL_RST);
    chkVal("svc read", wdt_pkg::SVC_ADDR, 16'h0000);
    chkVal("unmapped", 32'hFFFF_0370, 16'h0000);
    busWrite(wdt_pkg::CTRL_ADDR, 16'hFEDF);
    chkVal("ctrl mask", wdt_pkg::CTRL_ADDR, 16'hFEDF & wdt_pkg::CTRL_MASK);
    busWrite(wdt_pkg::VALUE_ADDR, rnd());
    chkVal("value ro", wdt_pkg::VALUE_ADDR, wdt_pkg::VALUE_RST);
    $display("test registers done");
    foreach (modes[i]) begin
      ctl = modes[i];
      ld = rnd();
      ld = ctl[8] ? (16'hFFFC | ld) : (ld & 16'h0003);
      busWrite(wdt_pkg::CTRL_ADDR, ctl);
      busWrite(wdt_pkg::LOAD_ADDR, ld);
      busWrite(wdt_pkg::SVC_ADDR, rnd());
      v = ld;
      expIrq = 1'b0;
      chkVal("reload", wdt_pkg::VALUE_ADDR, v);
      `CHK("irq clear", 1'b0, timerIrq)
      repeat (5) begin
        r = rnd();
        periphPowerDown <= r[0];
        tick();
        expIrq = expIrq | (v == (ctl[8] ? 16'hFFFF : 16'h0000));
        v = expNext(v, ld, ctl);
        chkVal("count", wdt_pkg::VALUE_ADDR, v);
        `CHK("irq", expIrq, timerIrq)
      end
    end
    periphPowerDown <= 1'b0;
    $display("test modes done");
    busWrite(wdt_pkg::CTRL_ADDR, 16'h00C1);
    busWrite(wdt_pkg::LOAD_ADDR, 16'h0003);
    busWrite(wdt_pkg::SVC_ADDR, 16'h0000);
    periphPowerDown <= 1'b1;
    tick();
    chkVal("pd halt", wdt_pkg::VALUE_ADDR, 16'h0003);
    periphPowerDown <= 1'b0;
    debugHalt <= 1'b1;
    tick();
    chkVal("debug halt", wdt_pkg::VALUE_ADDR, 16'h0003);
    debugHalt <= 1'b0;
    tick();
    chkVal("resume", wdt_pkg::VALUE_ADDR, 16'h0002);
    for (int k = 0; k < 2; k++) begin
      busWrite(wdt_pkg::CTRL_ADDR, k ? 16'h00C8 : 16'h00C4);
      busWrite(wdt_pkg::SVC_ADDR, 16'h0000);
      repeat (k ? 255 : 15) tick();
      chkVal("div hold", wdt_pkg::VALUE_ADDR, 16'h0003);
      tick();
      chkVal("div step", wdt_pkg::VALUE_ADDR, 16'h0002);
    end
    $display("test halt and prescale done");
    busWrite(wdt_pkg::LOAD_ADDR, 16'h0002);
    busWrite(wdt_pkg::CTRL_ADDR, 16'h0020);
    #1;
    `CHK("wd mode", 1'b1, wdModeActive)
    busWrite(wdt_pkg::LOAD_ADDR, 16'h1234);
    busWrite(wdt_pkg::CTRL_ADDR, 16'h0000);
    chkVal("load locked", wdt_pkg::LOAD_ADDR, 16'h0002);
    chkVal("ctrl locked", wdt_pkg::CTRL_ADDR, 16'h0020);
    busWrite(wdt_pkg::SVC_ADDR, rnd());
    chkVal("serviced", wdt_pkg::VALUE_ADDR, 16'h0002);
    tick();
    chkVal("wd down", wdt_pkg::VALUE_ADDR, 16'h0001);
    pulses = 0;
    tick();
    `CHK("reset pulses", 1, pulses)
    `CHK("no irq", 1'b0, timerIrq)
    chkVal("wd reload", wdt_pkg::VALUE_ADDR, 16'h0002);
    doReset();
    `CHK("mode cleared", 1'b0, wdModeActive)
    chkVal("ctrl cleared", wdt_pkg::CTRL_ADDR, wdt_pkg::CTRL_RST);
    busWrite(wdt_pkg::LOAD_ADDR, 16'h0001);
    busWrite(wdt_pkg::CTRL_ADDR, 16'h0022);
    busWrite(wdt_pkg::SVC_ADDR, 16'h0000);
    pulses = 0;
    tick();
    `CHK("wd irq", 1'b1, timerIrq)
    `CHK("no reset", 0, pulses)
    busWrite(wdt_pkg::SVC_ADDR, 16'h0000);
    #1;
    `CHK("wd irq clear", 1'b0, timerIrq)
    $display("test watchdog done");
    stop_test();
  end
endmodule : test_watchdog_timer_unit
